// File: hdl/evcss_outlet_ctrl.sv
// Purpose: One outlet supply controller
// Assumes: Inputs synchronous to clk_i
// Notes: Both outlets instantiate this; start offset gates the sequence
`include "evcss_regs.svh"
module evcss_outlet_ctrl #(
  parameter int unsigned SHUTDOWN_CYC = `EVCSS_SHUTDOWN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic go_i,
  input wire logic [15:0] min_volt_i,
  input wire logic [15:0] max_volt_i,
  // Link
  evcss_link_if.station link,
  // Status
  output logic energy_en_o,
  output logic asleep_o,
  output logic estop_o
);
  typedef enum logic [2:0] {
    EVCSS_S_IDLE, EVCSS_S_DISC, EVCSS_S_CHARGE, EVCSS_S_PAUSING, EVCSS_S_SLEEP,
    EVCSS_S_REFUSED, EVCSS_S_ESTOP, EVCSS_S_ENDED
  } evcss_state_e;
  evcss_state_e state_q;
  logic [1:0] wake_q;
  logic [31:0] sd_cnt_q;
  logic [6:0] pwm_cnt_q;
  logic hv_station;
  logic rsp_valid_q;
  evcss_pkg::evcss_msg_e rsp_msg_q;
  evcss_pkg::evcss_status_e rsp_status_q;
  assign hv_station = (max_volt_i >= 16'(`EVCSS_HV_LIMIT_V));

  //////////////////////////////////////////////////////////////////////////////
  // Session sequence
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= EVCSS_S_IDLE;
      wake_q <= 2'h0;
    end else begin
      case (state_q)
        EVCSS_S_IDLE: if (go_i) state_q <= EVCSS_S_DISC;
        EVCSS_S_DISC: if (link.cp_state == evcss_pkg::EVCSS_CP_LOST) begin
          state_q <= EVCSS_S_ENDED;
        end else if (link.req_valid && link.req_msg == evcss_pkg::EVCSS_MSG_PARAM) begin
          if (link.req_volt < min_volt_i) state_q <= EVCSS_S_REFUSED;
          else state_q <= EVCSS_S_CHARGE;
        end
        EVCSS_S_CHARGE: if (link.cp_state == evcss_pkg::EVCSS_CP_LOST) begin
          state_q <= EVCSS_S_ENDED;
        end else if (!link.pe_ok && hv_station) begin
          state_q <= EVCSS_S_ESTOP;
        end else if (link.req_valid && link.req_msg == evcss_pkg::EVCSS_MSG_POWER_STOP) begin
          state_q <= EVCSS_S_PAUSING;
        end
        EVCSS_S_PAUSING: if (link.cp_state == evcss_pkg::EVCSS_CP_LOST) begin
          state_q <= EVCSS_S_ENDED;
        end else if (link.req_valid && link.req_msg == evcss_pkg::EVCSS_MSG_LINK_PAUSE) begin
          state_q <= EVCSS_S_SLEEP;
          wake_q <= 2'h0;
        end
        EVCSS_S_SLEEP: begin
          // Only the pilot is watched while asleep
          case (wake_q)
            2'h0: if (link.cp_state == evcss_pkg::EVCSS_CP_C1) wake_q <= 2'h1;
            2'h1: if (link.cp_state == evcss_pkg::EVCSS_CP_B1) begin
              // Resume at once so the vehicle's next discovery request is seen
              wake_q <= 2'h0;
              state_q <= EVCSS_S_DISC;
            end
            default: wake_q <= 2'h0;
          endcase
        end
        EVCSS_S_REFUSED: state_q <= EVCSS_S_REFUSED;
        EVCSS_S_ESTOP: state_q <= EVCSS_S_ESTOP;
        EVCSS_S_ENDED: state_q <= EVCSS_S_ENDED;
        default: state_q <= EVCSS_S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Responses to vehicle requests
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_q <= 1'b0;
      rsp_msg_q <= evcss_pkg::EVCSS_MSG_NONE;
      rsp_status_q <= evcss_pkg::EVCSS_ST_OK;
    end else begin
      rsp_valid_q <= link.req_valid && state_q != EVCSS_S_SLEEP && state_q != EVCSS_S_IDLE
        && !(state_q == EVCSS_S_REFUSED && link.req_msg != evcss_pkg::EVCSS_MSG_PARAM);
      rsp_msg_q <= link.req_msg;
      if (state_q == EVCSS_S_DISC && link.req_volt < min_volt_i) begin
        rsp_status_q <= evcss_pkg::EVCSS_ST_SHUTDOWN;
      end else if (state_q == EVCSS_S_REFUSED || state_q == EVCSS_S_ENDED) begin
        rsp_status_q <= evcss_pkg::EVCSS_ST_SHUTDOWN;
      end else if (state_q == EVCSS_S_ESTOP) begin
        rsp_status_q <= evcss_pkg::EVCSS_ST_EMERGENCY;
      end else begin
        rsp_status_q <= evcss_pkg::EVCSS_ST_OK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Emergency shutdown timer within detect plus perform budget
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sd_cnt_q <= 32'h0;
    end else if (state_q == EVCSS_S_ESTOP && sd_cnt_q < SHUTDOWN_CYC) begin
      sd_cnt_q <= sd_cnt_q + 32'h1;
    end
  end

  // Pilot generator period counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) pwm_cnt_q <= 7'h0;
    else if (pwm_cnt_q == 7'(`EVCSS_PWM_PERIOD - 1)) pwm_cnt_q <= 7'h0;
    else pwm_cnt_q <= pwm_cnt_q + 7'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    link.pwm_mode = evcss_pkg::EVCSS_PWM_RUN;
    link.pwm_level = 1'b1;
    if (state_q == EVCSS_S_SLEEP || state_q == EVCSS_S_IDLE) begin
      link.pwm_mode = evcss_pkg::EVCSS_PWM_OFF_12V;
    end else if (state_q == EVCSS_S_ESTOP) begin
      link.pwm_mode = evcss_pkg::EVCSS_PWM_OFF_12V;
    end else begin
      link.pwm_mode = evcss_pkg::EVCSS_PWM_WAKE5;
      link.pwm_level = (pwm_cnt_q < 7'(`EVCSS_WAKE_DUTY));
    end
  end
  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_msg = rsp_msg_q;
  assign link.rsp_status = rsp_status_q;
  assign energy_en_o = (state_q == EVCSS_S_CHARGE);
  assign asleep_o = (state_q == EVCSS_S_SLEEP);
  assign estop_o = (state_q == EVCSS_S_ESTOP);
endmodule : evcss_outlet_ctrl

// File: hdl/evcss_regs.svh
// Purpose: Constants for the charge session supervisor and vehicle end
// Assumes: 100 MHz clock
// Notes: Times in their own unit, shutdown cycle count derived from them; offset and pilot period given in cycles
`ifndef EVCSS_REGS_SVH
`define EVCSS_REGS_SVH
`define EVCSS_CLK_MHZ 100
`define EVCSS_DETECT_MS 10
`define EVCSS_PERFORM_MS 30
`define EVCSS_SHUTDOWN_CYC ((`EVCSS_DETECT_MS + `EVCSS_PERFORM_MS) * 1000 * `EVCSS_CLK_MHZ)
`define EVCSS_HV_LIMIT_V 60
`define EVCSS_SETTLE_BASE_MS 2000
`define EVCSS_SLEW_A_PER_S 20
`define EVCSS_PWM_PERIOD 100
`define EVCSS_WAKE_DUTY 5
`define EVCSS_OFFSET_CYC 1000
`endif

// File: hdl/evcss_pkg.sv
// Purpose: Shared types for the charge session supervisor
// Assumes: Nothing
// Notes: Message codes and pilot states travel over the link interface
package evcss_pkg;
  // Pilot states seen on the pilot line
  typedef enum logic [2:0] {
    EVCSS_CP_A, EVCSS_CP_B1, EVCSS_CP_B2, EVCSS_CP_C1, EVCSS_CP_C2, EVCSS_CP_LOST
  } evcss_cp_e;
  // Messages on the high-level exchange
  typedef enum logic [2:0] {
    EVCSS_MSG_NONE, EVCSS_MSG_PARAM, EVCSS_MSG_DEMAND, EVCSS_MSG_POWER_STOP,
    EVCSS_MSG_SESSION_PAUSE, EVCSS_MSG_LINK_PAUSE
  } evcss_msg_e;
  // Station status codes in responses
  typedef enum logic [1:0] {
    EVCSS_ST_OK, EVCSS_ST_SHUTDOWN, EVCSS_ST_EMERGENCY
  } evcss_status_e;
  // Pilot generator mode
  typedef enum logic [1:0] {
    EVCSS_PWM_OFF_12V, EVCSS_PWM_RUN, EVCSS_PWM_WAKE5
  } evcss_pwm_e;
endpackage : evcss_pkg

// File: hdl/evcss_link_if.sv
// Purpose: Link between one outlet supply controller and the vehicle
// Assumes: Single clock, messages are one-cycle strobes
// Notes: Requests flow vehicle to station, responses the other way
interface evcss_link_if;
  logic req_valid;
  evcss_pkg::evcss_msg_e req_msg;
  logic [15:0] req_volt;
  logic [15:0] req_curr;
  logic rsp_valid;
  evcss_pkg::evcss_msg_e rsp_msg;
  evcss_pkg::evcss_status_e rsp_status;
  evcss_pkg::evcss_cp_e cp_state;
  evcss_pkg::evcss_pwm_e pwm_mode;
  logic pwm_level;
  logic pe_ok;
  modport station (input req_valid, req_msg, req_volt, req_curr, cp_state, pe_ok,
                   output rsp_valid, rsp_msg, rsp_status, pwm_mode, pwm_level);
  modport vehicle (output req_valid, req_msg, req_volt, req_curr, cp_state, pe_ok,
                   input rsp_valid, rsp_msg, rsp_status, pwm_mode, pwm_level);
endinterface : evcss_link_if

// File: hdl/evcss_station.sv
// Purpose: Dual-outlet station end of the charge session supervisor
// Assumes: One clock, inputs synchronous to clk_i
// Notes: Outlet two starts a configurable offset after outlet one
// Overview of operation
// - Refuse advance when vehicle limit below minimum
// - Discovery response carries shutdown status code
// - Each outlet runs independently, offset between them
// - Vehicle sends current demands each step
// - Vehicle waits settling time before judging
// - Vehicle sends stop request, awaits response
// - Vehicle then sends session pause request
// - Vehicle then pauses its data link
// - Paused station sleeps, pilot steady high
// - Vehicle wakes station with B1-C1-B1 toggle
// - Wake restarts pilot at five percent
// - Lost pilot ends session, blocks energy, except while asleep
// - High-voltage station shuts down on earth loss
// - Shutdown budget is detection plus execution
// - Earth loss switches pilot generator off
`include "evcss_regs.svh"
module evcss_station #(
  parameter int unsigned OFFSET_CYC = `EVCSS_OFFSET_CYC,
  parameter int unsigned SHUTDOWN_CYC = `EVCSS_SHUTDOWN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic start_i,
  input wire logic [15:0] min_volt_i,
  input wire logic [15:0] max_volt_i,
  // Links to vehicles
  evcss_link_if.station link_one,
  evcss_link_if.station link_two,
  // Status
  output logic [1:0] energy_en_o,
  output logic [1:0] asleep_o,
  output logic [1:0] estop_o
);
  logic [31:0] off_cnt_q;
  logic go_one_q;
  logic go_two_q;

  //////////////////////////////////////////////////////////////////////////////
  // Offset between the two outlet controllers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      off_cnt_q <= 32'h0;
      go_one_q <= 1'b0;
      go_two_q <= 1'b0;
    end else begin
      if (start_i) go_one_q <= 1'b1;
      if (go_one_q && off_cnt_q < OFFSET_CYC) off_cnt_q <= off_cnt_q + 32'h1;
      // Count this edge too, so outlet two trails outlet one by exactly OFFSET_CYC
      if (go_one_q && off_cnt_q + 32'h1 >= OFFSET_CYC) go_two_q <= 1'b1;
    end
  end

  // Outlet one supply controller
  evcss_outlet_ctrl #(.SHUTDOWN_CYC(SHUTDOWN_CYC)) u_one (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go_one_q),
    .min_volt_i(min_volt_i), .max_volt_i(max_volt_i), .link(link_one),
    .energy_en_o(energy_en_o[0]), .asleep_o(asleep_o[0]), .estop_o(estop_o[0])
  );
  // Outlet two supply controller
  evcss_outlet_ctrl #(.SHUTDOWN_CYC(SHUTDOWN_CYC)) u_two (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go_two_q),
    .min_volt_i(min_volt_i), .max_volt_i(max_volt_i), .link(link_two),
    .energy_en_o(energy_en_o[1]), .asleep_o(asleep_o[1]), .estop_o(estop_o[1])
  );
endmodule : evcss_station

// File: hdl/evcss_vehicle.sv
// Purpose: Vehicle end driving one outlet link
// Assumes: One clock, responses are one-cycle strobes
// Notes: Runs discovery, demand, pause and wake sequence on user command
`include "evcss_regs.svh"
module evcss_vehicle #(
  parameter int unsigned SETTLE_CYC = 1000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // User side
  input wire logic start_i,
  input wire logic pause_i,
  input wire logic wake_i,
  input wire logic pe_ok_i,
  input wire logic [15:0] max_volt_i,
  input wire logic [15:0] target_curr_i,
  output logic settled_o,
  // Link
  evcss_link_if.vehicle link
);
  typedef enum logic [3:0] {
    EVCSS_V_IDLE, EVCSS_V_DISC, EVCSS_V_WAITD, EVCSS_V_DEMAND, EVCSS_V_STOP,
    EVCSS_V_SESS, EVCSS_V_LINK, EVCSS_V_PAUSED, EVCSS_V_C1, EVCSS_V_B1
  } evcss_vstate_e;
  evcss_vstate_e st_q;
  logic [31:0] settle_q;
  logic [15:0] volt_q;
  logic [15:0] curr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Vehicle sequence
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= EVCSS_V_IDLE;
      volt_q <= 16'h0;
      curr_q <= 16'h0;
    end else begin
      volt_q <= max_volt_i;
      curr_q <= target_curr_i;
      case (st_q)
        EVCSS_V_IDLE: if (start_i) st_q <= EVCSS_V_DISC;
        EVCSS_V_DISC: st_q <= EVCSS_V_WAITD;
        EVCSS_V_WAITD: if (link.rsp_valid) st_q <= EVCSS_V_DEMAND;
        EVCSS_V_DEMAND: if (pause_i && settle_q >= SETTLE_CYC) st_q <= EVCSS_V_STOP;
        EVCSS_V_STOP: if (link.rsp_valid && link.rsp_msg == evcss_pkg::EVCSS_MSG_POWER_STOP) begin
          st_q <= EVCSS_V_SESS;
        end
        EVCSS_V_SESS: if (link.rsp_valid && link.rsp_msg == evcss_pkg::EVCSS_MSG_SESSION_PAUSE) begin
          st_q <= EVCSS_V_LINK;
        end
        EVCSS_V_LINK: st_q <= EVCSS_V_PAUSED;
        EVCSS_V_PAUSED: if (wake_i) st_q <= EVCSS_V_C1;
        EVCSS_V_C1: st_q <= EVCSS_V_B1;
        EVCSS_V_B1: st_q <= EVCSS_V_DISC;
        default: st_q <= EVCSS_V_IDLE;
      endcase
    end
  end

  // Settling interval counter during demand
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) settle_q <= 32'h0;
    else if (st_q != EVCSS_V_DEMAND) settle_q <= 32'h0;
    else if (settle_q < SETTLE_CYC) settle_q <= settle_q + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link drive
  always_comb begin
    link.req_valid = 1'b0;
    link.req_msg = evcss_pkg::EVCSS_MSG_NONE;
    case (st_q)
      EVCSS_V_DISC: begin
        link.req_valid = 1'b1;
        link.req_msg = evcss_pkg::EVCSS_MSG_PARAM;
      end
      EVCSS_V_DEMAND: begin
        // One demand per answer keeps the response a single-cycle strobe
        link.req_valid = !link.rsp_valid;
        link.req_msg = evcss_pkg::EVCSS_MSG_DEMAND;
      end
      EVCSS_V_LINK: begin
        link.req_valid = 1'b1;
        link.req_msg = evcss_pkg::EVCSS_MSG_LINK_PAUSE;
      end
      default: begin
        link.req_valid = (st_q == EVCSS_V_STOP || st_q == EVCSS_V_SESS) && !link.rsp_valid;
        link.req_msg = (st_q == EVCSS_V_SESS) ? evcss_pkg::EVCSS_MSG_SESSION_PAUSE
                                               : evcss_pkg::EVCSS_MSG_POWER_STOP;
      end
    endcase
  end
  assign link.req_volt = volt_q;
  assign link.req_curr = curr_q;
  assign link.cp_state = (st_q == EVCSS_V_C1) ? evcss_pkg::EVCSS_CP_C1 : evcss_pkg::EVCSS_CP_B1;
  assign link.pe_ok = pe_ok_i;
  assign settled_o = (settle_q >= SETTLE_CYC);
endmodule : evcss_vehicle

// File: test/evcss_link_properties.sv
// Purpose: Timing checks on the outlet one link and its status
// Assumes: One clock, rst_i asynchronous active high
// Notes: Instantiated beside link_one, no bind
module evcss_link_properties #(
  parameter int SHUTDOWN_CYC = 100
) (
  // Clock, reset, configuration
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] min_volt_i,
  input wire logic [15:0] max_volt_i,
  // Link signals
  input wire logic req_valid,
  input wire evcss_pkg::evcss_msg_e req_msg,
  input wire logic [15:0] req_volt,
  input wire logic rsp_valid,
  input wire evcss_pkg::evcss_msg_e rsp_msg,
  input wire evcss_pkg::evcss_status_e rsp_status,
  input wire evcss_pkg::evcss_cp_e cp_state,
  input wire evcss_pkg::evcss_pwm_e pwm_mode,
  input wire logic pwm_level,
  input wire logic pe_ok,
  // Station status
  input wire logic [1:0] energy_en_o,
  input wire logic [1:0] asleep_o,
  input wire logic [1:0] estop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////
  rsp_one_cycle_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response strobe held too long");
  param_shutdown_a: assert property (rsp_valid && $past(req_valid) &&
    $past(req_msg) == evcss_pkg::EVCSS_MSG_PARAM && $past(req_volt) < min_volt_i
    |-> rsp_status == evcss_pkg::EVCSS_ST_SHUTDOWN) else $error("no shutdown code");
  no_advance_a: assert property (rsp_valid && rsp_status == evcss_pkg::EVCSS_ST_SHUTDOWN
    |=> (!rsp_valid || rsp_msg == evcss_pkg::EVCSS_MSG_PARAM) [*8])
    else $error("exchange advanced after refusal");
  refuse_no_energy_a: assert property (rsp_status == evcss_pkg::EVCSS_ST_SHUTDOWN
    && rsp_valid |-> !energy_en_o[0]) else $error("energy on after refusal");
  sleep_entry_a: assert property (req_valid && req_msg == evcss_pkg::EVCSS_MSG_LINK_PAUSE
    |=> asleep_o[0]) else $error("no sleep after link pause");
  sleep_pilot_a: assert property (asleep_o[0] |->
    pwm_mode == evcss_pkg::EVCSS_PWM_OFF_12V && pwm_level) else $error("pilot not steady");
  sleep_frozen_a: assert property (asleep_o[0] && $past(asleep_o[0])
    |-> !rsp_valid && !energy_en_o[0]) else $error("activity while asleep");
  wake_toggle_a: assert property (asleep_o[0] && cp_state == evcss_pkg::EVCSS_CP_C1
    ##1 cp_state == evcss_pkg::EVCSS_CP_B1 |-> ##[1:3] pwm_mode == evcss_pkg::EVCSS_PWM_WAKE5)
    else $error("no wake after toggle");
  wake_duty_a: assert property (pwm_mode == evcss_pkg::EVCSS_PWM_WAKE5 && $rose(pwm_level)
    |-> pwm_level [*5] ##1 (!pwm_level || pwm_mode != evcss_pkg::EVCSS_PWM_WAKE5))
    else $error("wake pulse width wrong");
  estop_entry_a: assert property (!pe_ok && energy_en_o[0] && max_volt_i >= 16'h003C
    |=> estop_o[0]) else $error("no shutdown on earth loss");
  estop_budget_a: assert property (!pe_ok && energy_en_o[0]
    |-> ##[1:SHUTDOWN_CYC] !energy_en_o[0]) else $error("shutdown too slow");
  estop_pilot_a: assert property (estop_o[0] |->
    pwm_mode == evcss_pkg::EVCSS_PWM_OFF_12V) else $error("pilot running in shutdown");
  stop_hold_a: assert property (req_valid && req_msg == evcss_pkg::EVCSS_MSG_POWER_STOP
    |=> (rsp_valid && rsp_msg == evcss_pkg::EVCSS_MSG_POWER_STOP)
    || (req_valid && req_msg == evcss_pkg::EVCSS_MSG_POWER_STOP)) else $error("stop request dropped");
  sess_after_stop_a: assert property (
    rsp_valid && rsp_msg == evcss_pkg::EVCSS_MSG_POWER_STOP
    |-> ##[1:3] req_valid && req_msg == evcss_pkg::EVCSS_MSG_SESSION_PAUSE)
    else $error("no session pause after stop answer");
  link_after_sess_a: assert property (
    rsp_valid && rsp_msg == evcss_pkg::EVCSS_MSG_SESSION_PAUSE
    |-> ##[1:3] req_valid && req_msg == evcss_pkg::EVCSS_MSG_LINK_PAUSE)
    else $error("no link pause after session answer");
  wake_c1_b1_a: assert property (asleep_o[0] && cp_state == evcss_pkg::EVCSS_CP_C1
    |=> cp_state == evcss_pkg::EVCSS_CP_B1) else $error("pilot toggle incomplete");
endmodule : evcss_link_properties

// File: test/tb_top.sv
// Purpose: Station against one vehicle end, outlet two driven by the bench
// Assumes: 100 MHz clock, shortened shutdown and offset counts
// Notes: Terminal states are left by a fresh reset
`include "evcss_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned OFFSET_CYC = 20;
  localparam int unsigned SHUTDOWN_CYC = 100;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic v_start = 1'b0;
  logic v_pause = 1'b0;
  logic v_wake = 1'b0;
  logic v_pe_ok = 1'b1;
  logic [15:0] v_max_volt = 16'h0190;
  logic [15:0] min_volt = 16'h00C8;
  logic [15:0] max_volt = 16'h01F4;
  logic settled;
  logic [1:0] energy_en;
  logic [1:0] asleep;
  logic [1:0] estop;
  int n_mismatch = 0;
  int samples_checked = 0;
  evcss_link_if link_one ();
  evcss_link_if link_two ();
  // Clock
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////
  evcss_station #(.OFFSET_CYC(OFFSET_CYC), .SHUTDOWN_CYC(SHUTDOWN_CYC)) i_evcss_station (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .min_volt_i(min_volt),
    .max_volt_i(max_volt), .link_one(link_one), .link_two(link_two),
    .energy_en_o(energy_en), .asleep_o(asleep), .estop_o(estop));
  evcss_vehicle #(.SETTLE_CYC(10)) i_evcss_vehicle (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(v_start), .pause_i(v_pause), .wake_i(v_wake),
    .pe_ok_i(v_pe_ok), .max_volt_i(v_max_volt), .target_curr_i(16'h0020),
    .settled_o(settled), .link(link_one));
  evcss_link_properties #(.SHUTDOWN_CYC(SHUTDOWN_CYC)) i_evcss_link_properties (
    .clk_i(clk_i), .rst_i(rst_i), .min_volt_i(min_volt), .max_volt_i(max_volt),
    .req_valid(link_one.req_valid), .req_msg(link_one.req_msg),
    .req_volt(link_one.req_volt), .rsp_valid(link_one.rsp_valid),
    .rsp_msg(link_one.rsp_msg), .rsp_status(link_one.rsp_status),
    .cp_state(link_one.cp_state), .pwm_mode(link_one.pwm_mode),
    .pwm_level(link_one.pwm_level), .pe_ok(link_one.pe_ok),
    .energy_en_o(energy_en), .asleep_o(asleep), .estop_o(estop));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic do_reset();
    @(posedge clk_i) rst_i <= 1'b1;
    start_i <= 1'b0;
    v_start <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset
  // Outlet two requests from the bench in the vehicle's place
  task automatic send_two(input evcss_pkg::evcss_msg_e msg);
    @(posedge clk_i) link_two.req_valid <= 1'b1;
    link_two.req_msg <= msg;
    @(posedge clk_i) link_two.req_valid <= 1'b0;
    tick(3);
  endtask : send_two
  task automatic test_offset();
    int t1 = -1;
    int t2 = -1;
    check(link_one.pwm_mode, evcss_pkg::EVCSS_PWM_OFF_12V);
    @(posedge clk_i) start_i <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      tick();
      if (t1 < 0 && link_one.pwm_mode !== evcss_pkg::EVCSS_PWM_OFF_12V) t1 = i;
      if (t2 < 0 && link_two.pwm_mode !== evcss_pkg::EVCSS_PWM_OFF_12V) t2 = i;
    end
    check(16'(t2 - t1), 16'(OFFSET_CYC));
    $display("offset test done");
  endtask : test_offset
  task automatic test_pause_wake();
    int highs = 0;
    @(posedge clk_i) v_start <= 1'b1;
    for (int i = 0; i < 200 && energy_en[0] !== 1'b1; i++) tick();
    check(energy_en[0], 1'b1);
    check(link_one.req_curr, 16'h0020);
    for (int i = 0; i < 200 && settled !== 1'b1; i++) tick();
    check(settled, 1'b1);
    @(posedge clk_i) v_pause <= 1'b1;
    for (int i = 0; i < 200 && asleep[0] !== 1'b1; i++) tick();
    check(asleep[0], 1'b1);
    check(link_one.pwm_mode, evcss_pkg::EVCSS_PWM_OFF_12V);
    check(link_one.pwm_level, 1'b1);
    tick(20);
    check(asleep[0], 1'b1);
    @(posedge clk_i) v_pause <= 1'b0;
    v_wake <= 1'b1;
    for (int i = 0; i < 200 && link_one.pwm_mode !== evcss_pkg::EVCSS_PWM_WAKE5; i++) tick();
    check(link_one.pwm_mode, evcss_pkg::EVCSS_PWM_WAKE5);
    check(asleep[0], 1'b0);
    repeat (`EVCSS_PWM_PERIOD) begin
      tick();
      if (link_one.pwm_level === 1'b1) highs++;
    end
    check(16'(highs), 16'(`EVCSS_WAKE_DUTY));
    @(posedge clk_i) v_wake <= 1'b0;
    $display("pause and wake test done");
  endtask : test_pause_wake
  task automatic test_refuse();
    do_reset();
    @(posedge clk_i) v_max_volt <= 16'h00BE;
    start_i <= 1'b1;
    // Vehicle starts one edge later, so it enters discovery on the same edge as the station
    @(posedge clk_i) v_start <= 1'b1;
    for (int i = 0; i < 300 && link_one.rsp_valid !== 1'b1; i++) tick();
    check(link_one.rsp_msg, evcss_pkg::EVCSS_MSG_PARAM);
    check(link_one.rsp_status, evcss_pkg::EVCSS_ST_SHUTDOWN);
    tick(50);
    check(energy_en[0], 1'b0);
    $display("refusal test done");
  endtask : test_refuse
  task automatic test_estop();
    do_reset();
    @(posedge clk_i) v_max_volt <= 16'h0190;
    start_i <= 1'b1;
    // Vehicle starts one edge later, so it enters discovery on the same edge as the station
    @(posedge clk_i) v_start <= 1'b1;
    for (int i = 0; i < 300 && energy_en[0] !== 1'b1; i++) tick();
    @(posedge clk_i) v_pe_ok <= 1'b0;
    tick(3);
    check(estop[0], 1'b1);
    check(link_one.pwm_mode, evcss_pkg::EVCSS_PWM_OFF_12V);
    tick(SHUTDOWN_CYC);
    check(energy_en[0], 1'b0);
    $display("earth loss test done");
  endtask : test_estop
  task automatic test_lost();
    send_two(evcss_pkg::EVCSS_MSG_PARAM);
    check(energy_en[1], 1'b1);
    @(posedge clk_i) link_two.cp_state <= evcss_pkg::EVCSS_CP_LOST;
    tick(3);
    check(energy_en[1], 1'b0);
    send_two(evcss_pkg::EVCSS_MSG_PARAM);
    check(energy_en[1], 1'b0);
    $display("pilot loss test done");
  endtask : test_lost
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////
  // Outlet two idles plugged in with earth intact
  initial begin
    link_two.req_valid = 1'b0;
    link_two.req_msg = evcss_pkg::EVCSS_MSG_NONE;
    link_two.req_volt = 16'h0190;
    link_two.req_curr = 16'h0020;
    link_two.cp_state = evcss_pkg::EVCSS_CP_B1;
    link_two.pe_ok = 1'b1;
  end
  // Watchdog
  initial begin
    #500000;
    n_mismatch++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    test_offset();
    test_pause_wake();
    test_refuse();
    test_estop();
    test_lost();
    final_report();
  end
endmodule : tb_top
